// File: rtl/object_write_block.sv
// object write sequencer for one axis, ahb-lite register slave
// assumes the transfer service and axis state synchronous to hclk
//
// What this block does
// - selector at or above base writes object via transfer
// - abort response: error, 1800H, keep abort code
// - size code gives width 1,2,4,8 bytes
// - size code zero writes four bytes
// - other size codes fail with 34A2H
// - mode 0 issues the write at once
// - mode 1 waits for disabled or standstill
// - nonzero unused option bits fail 1A4EH
// - option bit 16 selects unsigned integer view
// - status bits 7:0 hold returned size
// - status bit 8 while transfer accepted
// - status bit 10 while request issuing
// - four transfers in flight, else 34A1H
// - value truncated, low bits kept
// - never commit to non-volatile storage
// - station lost fails pending write 1800H
// - write during homing fetch flagged to homing
// - execute starts write, inputs sampled then
// - busy high while executing
// - done high after successful write
//
// The register offsets and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`include "object_write_map.svh"
module object_write_block (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [3:0] axis_state,
  input wire logic homing_fetch,
  input wire logic [2:0] inflight_count,
  output logic xfer_req,
  output logic [15:0] xfer_index,
  output logic [7:0] xfer_subindex,
  output logic [3:0] xfer_bytes,
  output ow_pkg::raw_word_t xfer_data,
  output logic xfer_unsigned,
  output logic xfer_store_nv,
  input wire logic xfer_accept,
  input wire logic xfer_done,
  input wire logic xfer_abort,
  input wire logic [31:0] xfer_abort_code,
  input wire logic [7:0] xfer_resp_size,
  input wire logic station_lost,
  output logic busy,
  output logic done,
  output logic error,
  output ow_pkg::err_code_t error_code_out,
  output logic [31:0] abort_code_out,
  output logic [15:0] transfer_status_word,
  output logic homing_clash
);
  import ow_pkg::*;

  function automatic logic [3:0] size_bytes(input logic [7:0] code);
    case (code)
      `SIZE_DEFAULT: size_bytes = 4'd4;
      `SIZE_1B: size_bytes = 4'd1;
      `SIZE_2B: size_bytes = 4'd2;
      `SIZE_4B: size_bytes = 4'd4;
      `SIZE_8B: size_bytes = 4'd8;
      default: size_bytes = 4'd0;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // ahb-lite slave
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic exec_q, exec_d;
  logic [31:0] sel_q, sel_d, vlo_q, vlo_d, vhi_q, vhi_d, opt_q, opt_d;
  logic mode_q, mode_d;
  logic addr_ok;
  conv_if cv ();

  assign addr_ok = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  always_comb begin
    wr_pend_d = addr_ok && hwrite;
    wr_addr_d = haddr[7:0];
    rdata_d = rdata_q;
    exec_d = exec_q;
    sel_d = sel_q;
    vlo_d = vlo_q;
    vhi_d = vhi_q;
    mode_d = mode_q;
    opt_d = opt_q;
    if (wr_pend_q) begin
      case (wr_addr_q)
        `OFS_CTRL: exec_d = hwdata[0];
        `OFS_SELECTOR: sel_d = hwdata;
        `OFS_VALUE_LO: vlo_d = hwdata;
        `OFS_VALUE_HI: vhi_d = hwdata;
        `OFS_MODE: mode_d = hwdata[0];
        `OFS_OPTIONS: opt_d = hwdata;
        default: ;
      endcase
    end
    if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        `OFS_CTRL: rdata_d = {31'h0, exec_q};
        `OFS_SELECTOR: rdata_d = sel_q;
        `OFS_VALUE_LO: rdata_d = vlo_q;
        `OFS_VALUE_HI: rdata_d = vhi_q;
        `OFS_MODE: rdata_d = {31'h0, mode_q};
        `OFS_OPTIONS: rdata_d = opt_q;
        `OFS_FLAGS: rdata_d = {29'h0, error, done, busy};
        `OFS_ERROR: rdata_d = {16'h0000, error_code_out};
        `OFS_ABORT: rdata_d = abort_code_out;
        `OFS_XSTATUS: rdata_d = {16'h0000, transfer_status_word};
        `OFS_CONV_LO: rdata_d = cv.readback[31:0];
        `OFS_CONV_HI: rdata_d = cv.readback[63:32];
        default: rdata_d = `RST_WORD;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= `RST_WORD;
      exec_q <= 1'b0;
      sel_q <= `RST_WORD;
      vlo_q <= `RST_WORD;
      vhi_q <= `RST_WORD;
      mode_q <= 1'b0;
      opt_q <= `RST_WORD;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q <= rdata_d;
      exec_q <= exec_d;
      sel_q <= sel_d;
      vlo_q <= vlo_d;
      vhi_q <= vhi_d;
      mode_q <= mode_d;
      opt_q <= opt_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // write sequencer
  seq_state_e st_q, st_d;
  logic prev_q, prev_d;
  logic [31:0] s_sel_q, s_sel_d, s_opt_q, s_opt_d;
  raw_word_t s_val_q, s_val_d;
  logic s_mode_q, s_mode_d;
  err_code_t err_q, err_d;
  logic [31:0] abort_q, abort_d;
  logic [7:0] rsize_q, rsize_d;
  logic start, opt_bad, sel_bad, limit_hit, axis_stopped;

  assign start = exec_q && !prev_q;
  assign opt_bad = (opt_q & ~`OPT_USED_MASK) != `RST_WORD;
  assign sel_bad = (sel_q < `SEL_MIN) || (size_bytes(sel_q[7:0]) == 4'd0);
  assign limit_hit = inflight_count >= `MAX_INFLIGHT;
  assign axis_stopped = (axis_state == `AXIS_DISABLED) || (axis_state == `AXIS_STANDSTILL);

  always_comb begin
    st_d = st_q;
    prev_d = exec_q;
    s_sel_d = s_sel_q;
    s_opt_d = s_opt_q;
    s_val_d = s_val_q;
    s_mode_d = s_mode_q;
    err_d = err_q;
    abort_d = abort_q;
    rsize_d = rsize_q;
    case (st_q)
      st_idle: begin
        err_d = 16'h0000;
        abort_d = `RST_WORD;
        if (start) begin
          // inputs captured at start
          s_sel_d = sel_q;
          s_opt_d = opt_q;
          s_val_d = {vhi_q, vlo_q};
          s_mode_d = mode_q;
          if (opt_bad) begin
            st_d = st_fail;
            err_d = `ERR_OPTION;
          end else if (sel_bad) begin
            st_d = st_fail;
            err_d = `ERR_SELECTOR;
          end else if (limit_hit) begin
            st_d = st_fail;
            err_d = `ERR_BUSY_LIMIT;
          end else if (mode_q) begin
            st_d = st_wait_stop;
          end else begin
            st_d = st_issue;
          end
        end
      end
      st_wait_stop: begin
        if (station_lost) begin
          st_d = st_fail;
          err_d = `ERR_COMM;
        end else if (axis_stopped) begin
          st_d = st_issue;
        end
      end
      st_issue: begin
        if (station_lost) begin
          st_d = st_fail;
          err_d = `ERR_COMM;
        end else if (xfer_accept) begin
          st_d = st_accept;
        end
      end
      st_accept: begin
        if (station_lost) begin
          st_d = st_fail;
          err_d = `ERR_COMM;
        end else if (xfer_abort) begin
          st_d = st_fail;
          err_d = `ERR_COMM;
          abort_d = xfer_abort_code;
        end else if (xfer_done) begin
          st_d = st_done;
          rsize_d = xfer_resp_size;
        end
      end
      st_done, st_fail: begin
        if (!exec_q) begin
          st_d = st_idle;
        end
      end
      default: st_d = st_idle;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= st_idle;
      prev_q <= 1'b0;
      s_sel_q <= `RST_WORD;
      s_opt_q <= `RST_WORD;
      s_val_q <= 64'h0000_0000_0000_0000;
      s_mode_q <= 1'b0;
      err_q <= 16'h0000;
      abort_q <= `RST_WORD;
      rsize_q <= 8'h00;
    end else begin
      st_q <= st_d;
      prev_q <= prev_d;
      s_sel_q <= s_sel_d;
      s_opt_q <= s_opt_d;
      s_val_q <= s_val_d;
      s_mode_q <= s_mode_d;
      err_q <= err_d;
      abort_q <= abort_d;
      rsize_q <= rsize_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // conversion and outputs
  assign cv.value_bits = s_val_q;
  assign cv.width_bytes = size_bytes(s_sel_q[7:0]);
  assign cv.unsigned_mode = s_opt_q[`OPT_UNSIGNED_BIT];

  value_convert u_conv (
    .c(cv.conv)
  );

  assign xfer_req = st_q == st_issue;
  assign xfer_index = s_sel_q[31:16];
  assign xfer_subindex = s_sel_q[15:8];
  assign xfer_bytes = cv.width_bytes;
  assign xfer_data = cv.wire_data;
  assign xfer_unsigned = cv.unsigned_mode;
  assign xfer_store_nv = 1'b0;
  assign busy = (st_q == st_wait_stop) || (st_q == st_issue) || (st_q == st_accept);
  assign done = st_q == st_done;
  assign error = st_q == st_fail;
  assign error_code_out = error ? err_q : 16'h0000;
  assign abort_code_out = error ? abort_q : `RST_WORD;
  always_comb begin
    transfer_status_word = {8'h00, rsize_q};
    transfer_status_word[`XS_ACCEPT_BIT] = st_q == st_accept;
    transfer_status_word[`XS_ISSUE_BIT] = st_q == st_issue;
  end
  assign homing_clash = homing_fetch && (xfer_req || st_q == st_accept);

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence good_start;
    st_q == st_idle && start && !opt_bad && !sel_bad && !limit_hit;
  endsequence

  busy_excl_a: assert property (busy |-> !done && !error)
    else $error("busy overlaps a result");
  codes_zero_a: assert property (!error |-> error_code_out == 16'h0000 && abort_code_out == `RST_WORD)
    else $error("codes nonzero without error");
  opt_reject_a: assert property (st_q == st_idle && start && opt_bad |=> error && error_code_out == 16'h1A4E)
    else $error("bad options not refused");
  sel_reject_a: assert property (st_q == st_idle && start && !opt_bad && sel_bad |=> error_code_out == 16'h34A2)
    else $error("bad selector not refused");
  busy_limit_a: assert property (st_q == st_idle && start && !opt_bad && !sel_bad && limit_hit
    |=> error_code_out == 16'h34A1)
    else $error("transfer limit not enforced");
  now_issue_a: assert property (good_start ##0 !mode_q |=> xfer_req && busy)
    else $error("immediate write not issued");
  queued_hold_a: assert property (st_q == st_wait_stop && !axis_stopped && !station_lost |=> !xfer_req)
    else $error("queued write issued while moving");
  mode_wait_a: assert property (st_q == st_wait_stop |-> s_mode_q)
    else $error("write held without queued mode");
  abort_store_a: assert property (st_q == st_accept && xfer_abort && !station_lost
    |=> error && error_code_out == 16'h1800 && abort_code_out == $past(xfer_abort_code))
    else $error("abort response not reported");
  lost_fail_a: assert property (busy && station_lost |=> error && error_code_out == 16'h1800)
    else $error("lost station not failed");
  done_hold_a: assert property (done && exec_q |=> done)
    else $error("done dropped while execute high");
  status_bits_a: assert property (xfer_req |-> transfer_status_word[10] && !transfer_status_word[8])
    else $error("issue bit wrong");
  default_width_a: assert property (xfer_req && s_sel_q[7:0] == 8'h00 |-> xfer_bytes == 4'd4)
    else $error("default size not four bytes");
endmodule

// File: inc/object_write_map.svh
// offsets, field positions, codes and limits of the object write block
// assumes inclusion by bare name from the design files
`ifndef OBJECT_WRITE_MAP_SVH
`define OBJECT_WRITE_MAP_SVH
`define OFS_CTRL 8'h00
`define OFS_SELECTOR 8'h04
`define OFS_VALUE_LO 8'h08
`define OFS_VALUE_HI 8'h0C
`define OFS_MODE 8'h10
`define OFS_OPTIONS 8'h14
`define OFS_FLAGS 8'h18
`define OFS_ERROR 8'h1C
`define OFS_ABORT 8'h20
`define OFS_XSTATUS 8'h24
`define OFS_CONV_LO 8'h28
`define OFS_CONV_HI 8'h2C
`define RST_WORD 32'h0000_0000
`define SEL_MIN 32'h0001_0000
`define SIZE_DEFAULT 8'h00
`define SIZE_1B 8'h08
`define SIZE_2B 8'h10
`define SIZE_4B 8'h20
`define SIZE_8B 8'h40
`define OPT_UNSIGNED_BIT 16
`define OPT_USED_MASK 32'h0001_0000
`define XS_ACCEPT_BIT 8
`define XS_ISSUE_BIT 10
`define ERR_COMM 16'h1800
`define ERR_OPTION 16'h1A4E
`define ERR_SELECTOR 16'h34A2
`define ERR_BUSY_LIMIT 16'h34A1
`define MAX_INFLIGHT 3'h4
`define AXIS_DISABLED 4'h0
`define AXIS_STANDSTILL 4'h4
`endif

// File: inc/ow_pkg.sv
// types shared by the object write block and its value converter
// assumes nothing beyond a SystemVerilog compiler
package ow_pkg;
  typedef enum logic [2:0] {
    st_idle, st_wait_stop, st_issue, st_accept, st_done, st_fail
  } seq_state_e;
  typedef logic [15:0] err_code_t;
  typedef logic [63:0] raw_word_t;
endpackage

// File: inc/conv_if.sv
// carrier between the sequencer and the value converter
// assumes both ends in one clock domain, purely combinational path
`timescale 1ns/1ps
interface conv_if;
  ow_pkg::raw_word_t value_bits;
  logic [3:0] width_bytes;
  logic unsigned_mode;
  ow_pkg::raw_word_t wire_data;
  ow_pkg::raw_word_t readback;
  modport user (output value_bits, output width_bytes, output unsigned_mode,
                input wire_data, input readback);
  modport conv (input value_bits, input width_bytes, input unsigned_mode,
                output wire_data, output readback);
endinterface

// File: rtl/value_convert.sv
// double to integer conversion at the selected width
// assumes ieee double bits on the input, width of 1, 2, 4 or 8 bytes
`timescale 1ns/1ps
module value_convert (
  conv_if.conv c
);
  import ow_pkg::*;
  logic [10:0] expo;
  logic signed [12:0] shift;
  raw_word_t mant;
  raw_word_t mag;
  raw_word_t full;
  raw_word_t mask;
  always_comb begin
    expo = c.value_bits[62:52];
    shift = $signed({2'b00, expo}) - 13'sd1075;
    mant = {11'h000, 1'b1, c.value_bits[51:0]};
    // fraction dropped, low bits kept
    if (expo < 11'd1023) begin
      mag = 64'h0000_0000_0000_0000;
    end else if (shift >= 13'sd64) begin
      mag = 64'h0000_0000_0000_0000;
    end else if (shift >= 13'sd0) begin
      mag = mant << shift[5:0];
    end else begin
      mag = mant >> 6'((-shift));
    end
    full = c.value_bits[63] ? (~mag + 64'h0000_0000_0000_0001) : mag;
    case (c.width_bytes)
      4'd1: mask = 64'h0000_0000_0000_00FF;
      4'd2: mask = 64'h0000_0000_0000_FFFF;
      4'd4: mask = 64'h0000_0000_FFFF_FFFF;
      default: mask = 64'hFFFF_FFFF_FFFF_FFFF;
    endcase
    c.wire_data = full & mask;
    // signed or unsigned view of the written bits
    c.readback = c.wire_data;
    if (!c.unsigned_mode) begin
      case (c.width_bytes)
        4'd1: c.readback = {{56{full[7]}}, full[7:0]};
        4'd2: c.readback = {{48{full[15]}}, full[15:0]};
        4'd4: c.readback = {{32{full[31]}}, full[31:0]};
        default: c.readback = full;
      endcase
    end
  end
endmodule

// File: tb/station_model.sv
// far-side transfer service model: accepts a request, then ends it with done or abort
// assumes requests held level until accept, one clock with the block
`timescale 1ns/1ps
module station_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic xfer_req,
  input wire logic [3:0] xfer_bytes,
  input wire logic hold,
  input wire logic abort_en,
  input wire logic [1:0] lat,
  input wire logic [31:0] code,
  output logic xfer_accept,
  output logic xfer_done,
  output logic xfer_abort,
  output logic [31:0] xfer_abort_code,
  output logic [7:0] xfer_resp_size
);
  logic phase;
  logic [1:0] cnt;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 1'b0;
      cnt <= 2'h0;
      xfer_accept <= 1'b0;
      xfer_done <= 1'b0;
      xfer_abort <= 1'b0;
      xfer_abort_code <= 32'h0000_0000;
      xfer_resp_size <= 8'h00;
    end else begin
      // response fields invalid outside their pulse
      xfer_accept <= 1'b0;
      xfer_done <= 1'b0;
      xfer_abort <= 1'b0;
      xfer_abort_code <= ~xfer_abort_code;
      xfer_resp_size <= ~xfer_resp_size;
      cnt <= cnt + 2'h1;
      if (!phase) begin
        if (!xfer_req || hold) begin
          cnt <= 2'h0;
        end else if (cnt >= lat) begin
          xfer_accept <= 1'b1;
          phase <= 1'b1;
          cnt <= 2'h0;
        end
      end else if (cnt >= lat) begin
        phase <= 1'b0;
        cnt <= 2'h0;
        if (abort_en) begin
          xfer_abort <= 1'b1;
          xfer_abort_code <= code;
        end else begin
          xfer_done <= 1'b1;
          xfer_resp_size <= {4'h0, xfer_bytes};
        end
      end
    end
  end
endmodule

// File: tb/object_write_block_tb.sv
// self-checking bench for the object write block, ahb-lite master tasks
// assumes station_model as far side and the register map header
`timescale 1ns/1ps
`include "object_write_map.svh"
module object_write_block_tb;
  import ow_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, xfer_abort_code;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2, inflight_count = 0;
  logic [3:0] axis_state = 0, xfer_bytes;
  logic homing_fetch = 0, station_lost = 0, p_hold = 0, p_abort = 0;
  logic hreadyout, hresp, xfer_req, xfer_unsigned, xfer_store_nv, xfer_accept, xfer_done, xfer_abort;
  logic busy, done, error, homing_clash;
  logic [15:0] xfer_index, transfer_status_word;
  logic [7:0] xfer_subindex, xfer_resp_size;
  raw_word_t xfer_data;
  err_code_t error_code_out;
  logic [31:0] abort_code_out;
  int n_fail = 0, checked = 0;
  always #50 hclk = ~hclk;
  assign hready = hreadyout;
  object_write_block dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .axis_state(axis_state), .homing_fetch(homing_fetch), .inflight_count(inflight_count),
    .xfer_req(xfer_req), .xfer_index(xfer_index), .xfer_subindex(xfer_subindex), .xfer_bytes(xfer_bytes),
    .xfer_data(xfer_data), .xfer_unsigned(xfer_unsigned), .xfer_store_nv(xfer_store_nv),
    .xfer_accept(xfer_accept), .xfer_done(xfer_done), .xfer_abort(xfer_abort),
    .xfer_abort_code(xfer_abort_code), .xfer_resp_size(xfer_resp_size), .station_lost(station_lost),
    .busy(busy), .done(done), .error(error), .error_code_out(error_code_out), .abort_code_out(abort_code_out),
    .transfer_status_word(transfer_status_word), .homing_clash(homing_clash));
  station_model peer (.clk(hclk), .rst_n(hresetn), .xfer_req(xfer_req), .xfer_bytes(xfer_bytes),
    .hold(p_hold), .abort_en(p_abort), .lat(2'd2), .code(32'h0609_0030), .xfer_accept(xfer_accept),
    .xfer_done(xfer_done), .xfer_abort(xfer_abort), .xfer_abort_code(xfer_abort_code),
    .xfer_resp_size(xfer_resp_size));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task summarize;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task run(input logic [31:0] sel, input real v, input logic [31:0] mode, input logic [31:0] opt);
    logic [63:0] b;
    b = $realtobits(v);
    ahb(1, `OFS_SELECTOR, sel);
    ahb(1, `OFS_VALUE_LO, b[31:0]);
    ahb(1, `OFS_VALUE_HI, b[63:32]);
    ahb(1, `OFS_MODE, mode);
    ahb(1, `OFS_OPTIONS, opt);
    ahb(1, `OFS_CTRL, 32'h0000_0001);
  endtask
  task wait_req;
    for (int i = 0; i < 20 && xfer_req !== 1'b1; i++) @(posedge hclk);
  endtask
  task wait_end;
    for (int i = 0; i < 50 && done !== 1'b1 && error !== 1'b1; i++) @(posedge hclk);
  endtask
  task clr;
    ahb(1, `OFS_CTRL, 32'h0000_0000);
    repeat (2) @(posedge hclk);
    chk({busy, done, error, error_code_out}, 0);
    chk(abort_code_out, 0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    chk({hresp, hreadyout}, 2'b01);
    ahb(0, `OFS_FLAGS, 0);
    chk(rd, 0);
    ahb(0, `OFS_XSTATUS, 0);
    chk(rd, 0);
    ahb(0, 8'h40, 0);
    chk(rd, 0);
    chk({error_code_out, abort_code_out}, 0);
    $display("test reset finished");
  endtask
  task t_ok;
    axis_state <= 4'h2;
    run(32'h6099_0200, 100.0, 0, 0);
    wait_req;
    chk({xfer_req, busy, transfer_status_word[10], transfer_status_word[8]}, 4'b1110);
    chk({xfer_index, xfer_subindex, xfer_bytes}, {16'h6099, 8'h02, 4'h4});
    chk(xfer_data, 64'd100);
    chk(xfer_store_nv, 0);
    chk(homing_clash, 0);
    for (int i = 0; i < 20 && transfer_status_word[8] !== 1'b1; i++) @(posedge hclk);
    chk({transfer_status_word[8], transfer_status_word[10], xfer_req, busy}, 4'b1001);
    wait_end;
    chk({done, error, busy, transfer_status_word}, {3'b100, 16'h0004});
    repeat (3) @(posedge hclk);
    chk({done, busy}, 2'b10);
    ahb(0, `OFS_FLAGS, 0);
    chk(rd, 32'h2);
    clr;
    $display("test ok_write finished");
  endtask
  task automatic t_size;
    logic [7:0] codes [4] = '{8'h08, 8'h10, 8'h20, 8'h40};
    logic [31:0] conv [4] = '{32'hFFFF_FFF0, 32'h0000_D8F0, 32'hFFFF_D8F0, 32'hFFFF_D8F0};
    logic [63:0] full, m;
    axis_state <= 4'h0;
    full = -64'sd10000;
    for (int i = 0; i < 4; i++) begin
      m = (i == 3) ? 64'hFFFF_FFFF_FFFF_FFFF : (64'h1 << (8 << i)) - 64'h1;
      run({24'h2000_01, codes[i]}, -10000.4, 0, i[0] ? 32'h0001_0000 : 0);
      wait_req;
      chk(xfer_bytes, 4'h1 << i);
      chk(xfer_data, full & m);
      chk(xfer_unsigned, i[0]);
      wait_end;
      chk(transfer_status_word[7:0], 8'h1 << i);
      ahb(0, `OFS_CONV_LO, 0);
      chk(rd, conv[i]);
      clr;
    end
    $display("test sizes finished");
  endtask
  task automatic t_bad;
    logic [31:0] sel [4] = '{32'h6099_0211, 32'h0000_FF20, 32'h6099_0200, 32'h6099_0200};
    logic [31:0] opt [4] = '{0, 0, 32'h0002_0000, 0};
    err_code_t code [4] = '{`ERR_SELECTOR, `ERR_SELECTOR, `ERR_OPTION, `ERR_BUSY_LIMIT};
    for (int i = 0; i < 4; i++) begin
      inflight_count <= (i == 3) ? 3'h4 : 3'h3;
      run(sel[i], 1.0, 0, opt[i]);
      wait_end;
      chk({error, done, xfer_req, error_code_out}, {3'b100, code[i]});
      ahb(0, `OFS_ERROR, 0);
      chk(rd, code[i]);
      clr;
    end
    inflight_count <= 3'h0;
    $display("test refusals finished");
  endtask
  task t_abort;
    p_abort <= 1'b1;
    run(32'h6099_0220, 7.0, 0, 0);
    wait_end;
    chk({error, done, error_code_out, abort_code_out}, {2'b10, `ERR_COMM, 32'h0609_0030});
    p_abort <= 1'b0;
    clr;
    $display("test abort finished");
  endtask
  task t_lost;
    p_hold <= 1'b1;
    homing_fetch <= 1'b1;
    run(32'h6099_0220, 7.0, 0, 0);
    wait_req;
    chk(homing_clash, 1);
    station_lost <= 1'b1;
    wait_end;
    chk({error, error_code_out, abort_code_out}, {1'b1, `ERR_COMM, 32'h0});
    station_lost <= 1'b0;
    p_hold <= 1'b0;
    homing_fetch <= 1'b0;
    clr;
    $display("test station_lost finished");
  endtask
  task t_mode1;
    axis_state <= 4'h2;
    run(32'h6099_0220, 3.0, 1, 0);
    repeat (6) @(posedge hclk);
    chk({busy, xfer_req}, 2'b10);
    axis_state <= `AXIS_STANDSTILL;
    wait_req;
    chk(xfer_req, 1);
    wait_end;
    chk(done, 1);
    clr;
    $display("test after_stop finished");
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_ok;
    t_size;
    t_bad;
    t_abort;
    t_lost;
    t_mode1;
    summarize;
  end
  initial begin
    #3_000_000;
    n_fail++;
    summarize;
  end
endmodule
